// ==== src/wdt_timer.v ====
// watchdog timer: divider chain, timeout flag, delayed system reset,
// interrupt request, and an 8-bit register port on one system clock.
// assumes a synchronous register master and a reset distribution that
// routes sys_rst_out back to the core but not to this block's rst_b_in.
//
// What this block does
// - counter on system clock, idle until first restart
// - interval code picks 1,4,16,32 times 2^16
// - every expiry sets timeout flag, bit 3
// - reset 256 clocks after timeout if enabled
// - hold reset thirty clocks, set cause bit 2
// - software set of cause flag never resets
// - irq needs flag, watchdog enable, global enable
// - reset enable leaves counting and irq alone
// - software set of flag raises irq too
// - restart strobe self-clears after restarting counter
// - power-on reset disables the counter
// - watchdog reset restarts counting, stays enabled
// - reset value: mode 3, other bits zero
// - flag still set with irq and reset off
`timescale 1ns/10ps
`include "wdt_regs.vh"

module wdt_timer #(
  parameter CNT_W      = 22,
  parameter BASE_LOG2  = `WDT_BASE_LOG2,
  parameter RST_DELAY  = `WDT_RESET_DELAY,
  parameter RST_HOLD   = `WDT_RESET_HOLD
) (
  // clock and reset
  input  wire       clk_in,
  input  wire       rst_b_in,
  // register port
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  // system outputs
  output wire       wdt_irq_out,
  output reg        sys_rst_out,
  output wire       event_irq_out
);

  // reset sequencer states
  localparam [1:0] ST_RUN   = 2'b00;
  localparam [1:0] ST_DELAY = 2'b01;
  localparam [1:0] ST_HOLD  = 2'b10;

  // delay and hold loads, cut on purpose to the 9-bit phase counter
  localparam integer DELAY_M1   = RST_DELAY - 1;
  localparam integer HOLD_M1    = RST_HOLD - 1;
  localparam [8:0]   DELAY_LOAD = DELAY_M1[8:0];
  localparam [8:0]   HOLD_LOAD  = HOLD_M1[8:0];

  // one, at counter width
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  // control and register state
  reg [1:0]       interval_sel;
  reg             timeout_flag;
  reg             reset_cause_flag;
  reg             reset_enable;
  reg             restart_strobe;
  reg             counting;
  reg             watchdog_irq_enable;
  reg             global_irq_enable;
  reg [1:0]       irq_status;
  reg [1:0]       irq_mask;
  reg [CNT_W-1:0] count;
  reg [1:0]       state;
  reg [8:0]       phase_cnt;

  // next values of the clocked state
  reg [1:0]       next_interval_sel;
  reg             next_timeout_flag;
  reg             next_reset_cause_flag;
  reg             next_reset_enable;
  reg             next_restart_strobe;
  reg             next_counting;
  reg             next_watchdog_irq_enable;
  reg             next_global_irq_enable;
  reg [1:0]       next_irq_status;
  reg [1:0]       next_irq_mask;
  reg [CNT_W-1:0] next_count;
  reg [1:0]       next_state;
  reg [8:0]       next_phase;
  reg             next_sys_rst;
  reg [7:0]       next_rdata;

  // terminal count for an interval code
  function [CNT_W-1:0] limit_of;
    input [1:0] sel;
    reg   [5:0] mult;
    begin
      case (sel)
        2'b00:   mult = 6'h01;
        2'b01:   mult = 6'h04;
        2'b10:   mult = 6'h10;
        default: mult = 6'h20;
      endcase
      limit_of = ({{(CNT_W-6){1'b0}}, mult} << BASE_LOG2) - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // register address match, used by every strobe decode
  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // control register as software reads it; bits 5 and 4 read zero
  function [7:0] ctrl_image;
    input [1:0] sel;
    input       flag;
    input       cause;
    input       rst_en;
    input       restart;
    begin
      ctrl_image = {sel, 2'b00, flag, cause, rst_en, restart};
    end
  endfunction

  // write strobes decoded per register
  wire ctrl_wr = wr_in && addr_hit(addr_in, `WDT_CTRL_ADDR);
  wire stat_wr = wr_in && addr_hit(addr_in, `WDT_IRQ_STATUS_ADDR);
  wire mask_wr = wr_in && addr_hit(addr_in, `WDT_IRQ_MASK_ADDR);
  wire ien_wr  = wr_in && addr_hit(addr_in, `WDT_IRQ_EN_ADDR);

  // terminal count of the interval in use
  wire [CNT_W-1:0] cur_limit = limit_of(interval_sel);

  // restart request from a software write of the restart bit
  wire sw_restart = ctrl_wr && wdata_in[`WDT_RESTART_BIT];
  wire expire     = counting && (count == cur_limit);
  // reset fires only while still enabled and not restarted this cycle
  wire rst_fire   = (state == ST_DELAY) && (phase_cnt == 9'h000) && reset_enable
                    && !sw_restart;
  wire hold_done  = (state == ST_HOLD) && (phase_cnt == 9'h000);

  // divider chain next value; idle until the first restart, wraps at expiry
  always @* begin
    next_count    = count;
    next_counting = counting;
    if (sw_restart || hold_done) begin
      // restart from software or at the end of a watchdog reset
      next_count    = {CNT_W{1'b0}};
      next_counting = 1'b1;
    end else if (expire) begin
      // wrap and run on, so the flag sets every interval
      next_count = {CNT_W{1'b0}};
    end else if (counting) begin
      // reset enable plays no part here
      next_count = count + CNT_ONE;
    end
  end

  // divider chain registers; power-on reset stops the count
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count    <= {CNT_W{1'b0}};
      counting <= 1'b0;
    end else begin
      count    <= next_count;
      counting <= next_counting;
    end
  end

  // reset sequencer next state: delay after timeout, then hold system reset
  always @* begin
    next_state   = state;
    next_phase   = phase_cnt;
    next_sys_rst = sys_rst_out;
    case (state)
      ST_RUN: begin
        // a restart in the expiry cycle wins over the reset
        if (expire && reset_enable && !sw_restart) begin
          next_state = ST_DELAY;
          next_phase = DELAY_LOAD;
        end
      end
      ST_DELAY: begin
        if (sw_restart || !reset_enable) begin
          // restart or reset disable cancels the pending reset
          next_state = ST_RUN;
          next_phase = 9'h000;
        end else if (rst_fire) begin
          next_state   = ST_HOLD;
          next_phase   = HOLD_LOAD;
          next_sys_rst = 1'b1;
        end else begin
          next_phase = phase_cnt - 9'h001;
        end
      end
      ST_HOLD: begin
        if (hold_done) begin
          // counter restarts in this same cycle
          next_state   = ST_RUN;
          next_sys_rst = 1'b0;
        end else begin
          next_phase = phase_cnt - 9'h001;
        end
      end
      default: begin
        next_state   = ST_RUN;
        next_phase   = 9'h000;
        next_sys_rst = 1'b0;
      end
    endcase
  end

  // reset sequencer registers
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state       <= ST_RUN;
      phase_cnt   <= 9'h000;
      sys_rst_out <= 1'b0;
    end else begin
      state       <= next_state;
      phase_cnt   <= next_phase;
      sys_rst_out <= next_sys_rst;
    end
  end

  // control register next value; hardware sets win over software clears
  always @* begin
    next_interval_sel     = interval_sel;
    next_reset_enable     = reset_enable;
    next_timeout_flag     = timeout_flag;
    next_reset_cause_flag = reset_cause_flag;
    // strobe reads one for a single cycle, then clears itself
    next_restart_strobe   = sw_restart;
    if (ctrl_wr) begin
      next_interval_sel     = {wdata_in[`WDT_SEL_HI_BIT], wdata_in[`WDT_SEL_LO_BIT]};
      next_reset_enable     = wdata_in[`WDT_RST_EN_BIT];
      // software may set the flag to raise the irq itself
      next_timeout_flag     = wdata_in[`WDT_TIMEOUT_BIT];
      // writing the cause flag never starts a reset
      next_reset_cause_flag = wdata_in[`WDT_CAUSE_BIT];
    end
    if (expire) begin
      next_timeout_flag = 1'b1;
    end
    if (rst_fire) begin
      next_reset_cause_flag = 1'b1;
    end
  end

  // control register flops
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      interval_sel     <= 2'b11;
      timeout_flag     <= 1'b0;
      reset_cause_flag <= 1'b0;
      reset_enable     <= 1'b0;
      restart_strobe   <= 1'b0;
    end else begin
      interval_sel     <= next_interval_sel;
      timeout_flag     <= next_timeout_flag;
      reset_cause_flag <= next_reset_cause_flag;
      reset_enable     <= next_reset_enable;
      restart_strobe   <= next_restart_strobe;
    end
  end

  // interrupt enables, sticky event status and mask, next values
  always @* begin
    next_watchdog_irq_enable = watchdog_irq_enable;
    next_global_irq_enable   = global_irq_enable;
    next_irq_mask            = irq_mask;
    next_irq_status          = irq_status;
    if (ien_wr) begin
      next_watchdog_irq_enable = wdata_in[`WDT_IEN_WDT_BIT];
      next_global_irq_enable   = wdata_in[`WDT_IEN_GLOBAL_BIT];
    end
    if (mask_wr) begin
      next_irq_mask = wdata_in[1:0];
    end
    // write one to clear, then new events set; set wins
    if (stat_wr) begin
      next_irq_status = irq_status & ~wdata_in[1:0];
    end
    if (expire) begin
      next_irq_status[`WDT_EV_TIMEOUT_BIT] = 1'b1;
    end
    if (rst_fire) begin
      next_irq_status[`WDT_EV_RESET_BIT] = 1'b1;
    end
  end

  // interrupt register flops
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      watchdog_irq_enable <= 1'b0;
      global_irq_enable   <= 1'b0;
      irq_status          <= 2'b00;
      irq_mask            <= 2'b00;
    end else begin
      watchdog_irq_enable <= next_watchdog_irq_enable;
      global_irq_enable   <= next_global_irq_enable;
      irq_status          <= next_irq_status;
      irq_mask            <= next_irq_mask;
    end
  end

  // watchdog interrupt request
  assign wdt_irq_out = timeout_flag && watchdog_irq_enable && global_irq_enable;
  // event interrupt from sticky status
  assign event_irq_out = |(irq_status & irq_mask);

  // read data next value; zero unless a read strobe is taken
  always @* begin
    next_rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        `WDT_CTRL_ADDR: begin
          next_rdata = ctrl_image(interval_sel, timeout_flag, reset_cause_flag,
                                  reset_enable, restart_strobe);
        end
        `WDT_IRQ_STATUS_ADDR: begin
          next_rdata = {6'h00, irq_status};
        end
        `WDT_IRQ_MASK_ADDR: begin
          next_rdata = {6'h00, irq_mask};
        end
        `WDT_IRQ_EN_ADDR: begin
          next_rdata = {6'h00, global_irq_enable, watchdog_irq_enable};
        end
        default: begin
          // unmapped addresses read zero
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // read data flop, one cycle after the read strobe
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= next_rdata;
    end
  end

endmodule

// ==== shared/wdt_regs.vh ====
// constants for the watchdog timer block: register offset, bit fields,
// reset values and timing counts; included by the watchdog design file
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// register offsets (8-bit register port)
`define WDT_CTRL_ADDR        8'hD8
`define WDT_IRQ_STATUS_ADDR  8'hD9
`define WDT_IRQ_MASK_ADDR    8'hDA
`define WDT_IRQ_EN_ADDR      8'hDB

// control register fields
`define WDT_RESTART_BIT      0
`define WDT_RST_EN_BIT       1
`define WDT_CAUSE_BIT        2
`define WDT_TIMEOUT_BIT      3
`define WDT_SEL_LO_BIT       6
`define WDT_SEL_HI_BIT       7
`define WDT_CTRL_RESET       8'hC0

// interrupt enable register fields
`define WDT_IEN_WDT_BIT      0
`define WDT_IEN_GLOBAL_BIT   1

// interrupt status bits
`define WDT_EV_TIMEOUT_BIT   0
`define WDT_EV_RESET_BIT     1

// timing counts in system clocks
`define WDT_BASE_LOG2        16
`define WDT_RESET_DELAY      256
`define WDT_RESET_HOLD       30

`endif

// ==== tb/wdt_sva.sv ====
// checker on the watchdog timer ports
// assumes 30-clock reset hold, 16-clock base interval
`timescale 1ns/10ps
module wdt_sva (
  input wire       clk_in, rst_b_in, wr_in, rd_in,
  input wire [7:0] addr_in, wdata_in, rdata_out,
  input wire       wdt_irq_out, sys_rst_out, event_irq_out
);
  reg [9:0] gap;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // clocks since restart or end of hold
  always @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in) gap <= 10'h3FF;
    else if (wr_in && addr_in == 8'hD8 && wdata_in[0] || $fell(sys_rst_out)) gap <= 10'h000;
    else if (gap != 10'h3FF) gap <= gap + 10'h001;
  // reset pulse then release
  sequence s_hold; ##29 sys_rst_out ##1 !sys_rst_out; endsequence
  property p_hold; $rose(sys_rst_out) |-> s_hold; endproperty
  a_hold: assert property (p_hold) else $error("reset hold");
  property p_fell; $fell(sys_rst_out) |-> $past(sys_rst_out, 30); endproperty
  a_fell: assert property (p_fell) else $error("reset short");
  property p_gap; $rose(sys_rst_out) |-> gap > 10'h104; endproperty
  a_gap: assert property (p_gap) else $error("reset early");
  property p_idle; rdata_out != 8'h00 |-> $past(rd_in); endproperty
  a_idle: assert property (p_idle) else $error("read data idle");
  property p_unmap; rd_in && addr_in < 8'hD8 |=> rdata_out == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_rclr; rd_in && addr_in == 8'hD8 && !$past(wr_in) |=> !rdata_out[0]; endproperty
  a_rclr: assert property (p_rclr) else $error("restart stuck");
  property p_irq; wr_in && addr_in == 8'hDB && wdata_in[1:0] != 2'h3 |=> !wdt_irq_out; endproperty
  a_irq: assert property (p_irq) else $error("irq enable");
  property p_ev; wr_in && addr_in == 8'hDA && wdata_in[1:0] == 2'h0 |=> !event_irq_out; endproperty
  a_ev: assert property (p_ev) else $error("event mask");
endmodule
bind wdt_timer wdt_sva u_sva (.*);

// ==== tb/tb_watchdog_timer_with_reset.sv ====
// bench for the watchdog timer: codes, irqs, reset path
// assumes a 16-clock base interval and no reset feedback
`timescale 1ns/10ps
module tb_watchdog_timer_with_reset;
  reg        clk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, rd_q = 1'b0;
  reg  [7:0] addr_in = 8'h00, wdata_in = 8'h00, exp_q[$];
  wire [7:0] rdata_out;
  wire       wdt_irq_out, sys_rst_out, event_irq_out;
  integer    n_fail = 0, comparisons = 0, cyc = 0, seed = 72, n, m;
  always #5 clk_in = ~clk_in;
  wdt_timer #(.BASE_LOG2(4)) DUT (.*);
  // compare and count
  task chk(input [7:0] g, input [7:0] e);
    comparisons = comparisons + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one bus cycle: write if w, else read noting d
  task acc(input w, input [7:0] a, input [7:0] d);
    if (!w) exp_q.push_back(d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    {wr_in, rd_in} <= {w, !w};
    @(posedge clk_in);
    {wr_in, rd_in} <= 2'h0;
  endtask
  // output level at the falling edge
  task lvl(input [1:0] s, input e);
    @(negedge clk_in);
    chk({7'h00, s == 2'h0 ? wdt_irq_out : s == 2'h1 ? event_irq_out : sys_rst_out}, {7'h00, e});
  endtask
  task end_sim;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // read data against oldest note; hang limit
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (rd_q) chk(rdata_out, exp_q.pop_front());
    rd_q <= rd_in;
    if (cyc == 8000) begin
      n_fail = n_fail + 1;
      end_sim;
    end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    acc(1'h0, 8'hD8, 8'hC0);
    acc(1'h1, 8'($random(seed)) & 8'h7F, 8'($random(seed)));
    acc(1'h0, 8'($random(seed)) & 8'h7F, 8'h00);
    repeat (600) @(posedge clk_in);
    acc(1'h0, 8'hD8, 8'hC0);
    // each code: flag clear at expiry edge, set after
    for (m = 0; m < 4; m = m + 1) begin
      acc(1'h1, 8'hD8, 8'h00);
      acc(1'h1, 8'hD8, 8'h01);
      acc(1'h1, 8'hD8, {m[1:0], 6'h00});
      repeat ((m == 3 ? 512 : 16 << 2 * m) - 4) @(posedge clk_in);
      acc(1'h0, 8'hD8, {m[1:0], 6'h00});
      acc(1'h0, 8'hD8, {m[1:0], 6'h08});
    end
    // irq enables with software-set flag; event mask
    acc(1'h1, 8'hD8, 8'h00);
    acc(1'h1, 8'hD8, 8'h01);
    acc(1'h1, 8'hD8, 8'hC8);
    for (m = 0; m < 4; m = m + 1) begin
      acc(1'h1, 8'hDB, m[7:0]);
      lvl(2'h0, m == 3);
    end
    acc(1'h0, 8'hD9, 8'h01);
    acc(1'h1, 8'hDA, 8'h00);
    acc(1'h1, 8'hDA, 8'h03);
    lvl(2'h1, 1'b1);
    acc(1'h1, 8'hD9, 8'h01);
    lvl(2'h1, 1'b0);
    // software cause flag, no reset
    acc(1'h1, 8'hD8, 8'h04);
    repeat (300) @(posedge clk_in);
    lvl(2'h2, 1'b0);
    // watchdog reset: delay, hold, flags, again
    acc(1'h1, 8'hD8, 8'h00);
    acc(1'h1, 8'hD8, 8'h03);
    for (n = 0; !sys_rst_out && n < 400; n = n + 1) @(negedge clk_in);
    chk(8'(n - 256), 8'h11);
    for (n = 0; sys_rst_out && n < 40; n = n + 1) @(negedge clk_in);
    chk(8'(n), 8'h1E);
    acc(1'h0, 8'hD8, 8'h0E);
    acc(1'h0, 8'hD9, 8'h03);
    for (n = 0; !sys_rst_out && n < 400; n = n + 1) @(negedge clk_in);
    chk({7'h00, n > 250 && n < 300}, 8'h01);
    end_sim;
  end
endmodule
